// *** logic/mwe_consts.svh ***
// constants for the mfm write encoder buffer, skip and precompensation logic
`ifndef MWE_CONSTS_SVH
`define MWE_CONSTS_SVH

// ----------------------------------------
// buffer and skip counting
// ----------------------------------------
`define MWE_BUF_DEPTH 2
`define MWE_SKIP_CNT_W 3
// cell index (first 1 bit = 0) whose clock pulse is deleted
`define MWE_SKIP_CELL 3'h5

// ----------------------------------------
// precompensation window {last clk, last data, clk, data}
// ----------------------------------------
`define MWE_AHEAD_TAIL 3'h6
`define MWE_BEHIND_TAIL 3'h3
`define MWE_AHEAD_FULL 4'h1
`define MWE_BEHIND_FULL 4'h8

`endif

// *** logic/mwe_pkg.sv ***
// types shared by the mfm write encoder
package mwe_pkg;

    // ----------------------------------------
    // pin bundle, sampled through two flip-flops
    // ----------------------------------------
    typedef struct packed {
        logic nrz_in;
        logic bit_clk;
        logic double_rate_clock;
        logic skip_arm;
        logic precomp_gate;
        logic transfer_req_strobe;
        logic service_req_strobe;
        logic master_clear_n;
        logic select_n;
        logic addr_bit_low;
        logic addr_bit_high;
    } mwe_pins_s;

    // ----------------------------------------
    // one encoded bit cell held in the buffer
    // ----------------------------------------
    typedef struct packed {
        logic clk_pulse;
        logic data_pulse;
        logic ahead;
        logic behind;
    } mwe_cell_s;

    typedef enum logic [1:0] {
        SK_IDLE,
        SK_ARMED,
        SK_COUNT
    } mwe_skip_e;

endpackage

// *** logic/mwe_top.sv ***
// mfm write encoder with precompensation, skip logic and request latches
`include "mwe_consts.svh"

module mwe_top
    import mwe_pkg::*;
#(
    parameter int DEPTH = `MWE_BUF_DEPTH
) (
    // clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // encoder pins
    input wire logic nrz_in,
    input wire logic bit_clk,
    input wire logic double_rate_clock,
    input wire logic skip_arm,
    input wire logic precomp_gate,
    // encoder outputs
    output logic mfm_out,
    output logic shift_ahead,
    output logic shift_behind,
    output logic shift_none,
    output logic enc_ready,
    // request latch pins
    input wire logic transfer_req_strobe,
    input wire logic service_req_strobe,
    input wire logic master_clear_n,
    input wire logic select_n,
    input wire logic addr_bit_low,
    input wire logic addr_bit_high,
    // request outputs
    output logic transfer_request_n,
    output logic service_request_n
);
    localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam logic [PW:0] FULL = (PW + 1)'(DEPTH);
    localparam logic [PW-1:0] LAST = PW'(DEPTH - 1);

    // ----------------------------------------
    // pin synchronisers and edge detection
    // ----------------------------------------
    mwe_pins_s pins, sync1_r, sync2_r, last_r;
    logic bit_fall, dr_fall, skip_rise, tfr_fall, svc_fall;

    assign pins = '{nrz_in, bit_clk, double_rate_clock, skip_arm, precomp_gate,
                    transfer_req_strobe, service_req_strobe, master_clear_n,
                    select_n, addr_bit_low, addr_bit_high};

    // sync1_r feeds only sync2_r; edges are seen on the second stage
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            sync1_r <= '0;
            sync2_r <= '0;
            last_r <= '0;
        end else begin
            sync1_r <= pins;
            sync2_r <= sync1_r;
            last_r <= sync2_r;
        end
    end

    assign bit_fall = last_r.bit_clk & ~sync2_r.bit_clk;
    assign dr_fall = last_r.double_rate_clock & ~sync2_r.double_rate_clock;
    assign skip_rise = ~last_r.skip_arm & sync2_r.skip_arm;
    assign tfr_fall = last_r.transfer_req_strobe & ~sync2_r.transfer_req_strobe;
    assign svc_fall = last_r.service_req_strobe & ~sync2_r.service_req_strobe;

    // ----------------------------------------
    // encoder and skip logic
    // ----------------------------------------
    mwe_skip_e skip_st_r, skip_st_nxt;
    logic [`MWE_SKIP_CNT_W-1:0] skip_cnt_r, skip_cnt_nxt;
    logic prev_d_r, prev_d_nxt, prev_c_r, prev_c_nxt;
    logic suppress, clk_bit, dbit;
    logic [3:0] win;
    mwe_cell_s cell_in;

    // the deleted clock is the one of the fifth cell after the first 1
    assign suppress = (skip_st_r == SK_COUNT) && (skip_cnt_r == `MWE_SKIP_CELL);
    assign dbit = sync2_r.nrz_in;
    assign clk_bit = ~dbit & ~prev_d_r & ~suppress;
    assign win = {prev_c_r, prev_d_r, clk_bit, dbit};

    // one precomp choice per cell, applied to whichever pulse the cell has
    always_comb begin
        cell_in.clk_pulse = clk_bit;
        cell_in.data_pulse = dbit;
        cell_in.ahead = (win[2:0] == `MWE_AHEAD_TAIL) || (win == `MWE_AHEAD_FULL);
        cell_in.behind = (win[2:0] == `MWE_BEHIND_TAIL) || (win == `MWE_BEHIND_FULL);
    end

    // skip arms only on a rising skip_arm, so a held level never rearms
    always_comb begin
        skip_st_nxt = skip_st_r;
        skip_cnt_nxt = skip_cnt_r;
        prev_d_nxt = prev_d_r;
        prev_c_nxt = prev_c_r;
        if (bit_fall) begin
            prev_d_nxt = dbit;
            prev_c_nxt = clk_bit;
        end
        unique case (skip_st_r)
            SK_IDLE: begin
                if (skip_rise) begin
                    skip_st_nxt = SK_ARMED;
                end
            end
            SK_ARMED: begin
                // zero bits leave the armed state alone
                if (!sync2_r.skip_arm) begin
                    skip_st_nxt = SK_IDLE;
                end else if (bit_fall && dbit) begin
                    skip_st_nxt = SK_COUNT;
                    skip_cnt_nxt = `MWE_SKIP_CNT_W'(1);
                end
            end
            SK_COUNT: begin
                if (bit_fall) begin
                    if (suppress) begin
                        skip_st_nxt = SK_IDLE;
                    end else begin
                        skip_cnt_nxt = skip_cnt_r + `MWE_SKIP_CNT_W'(1);
                    end
                end
            end
        endcase
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            skip_st_r <= SK_IDLE;
            skip_cnt_r <= '0;
            prev_d_r <= 1'b0;
            prev_c_r <= 1'b0;
        end else begin
            skip_st_r <= skip_st_nxt;
            skip_cnt_r <= skip_cnt_nxt;
            prev_d_r <= prev_d_nxt;
            prev_c_r <= prev_c_nxt;
        end
    end

    // ----------------------------------------
    // cell buffer and double rate output stage
    // ----------------------------------------
    mwe_cell_s mem_r [DEPTH];
    mwe_cell_s cur;
    logic [PW-1:0] wr_r, wr_nxt, rd_r, rd_nxt;
    logic [PW:0] cnt_r, cnt_nxt;
    logic phase_r, phase_nxt, push, pop, pulse;
    logic mfm_nxt, ahead_nxt, behind_nxt, none_nxt, ready_nxt;

    // a full buffer refuses the cell; enc_ready warns the source first
    assign push = bit_fall && (cnt_r != FULL);
    assign pop = dr_fall && phase_r && (cnt_r != '0);
    assign cur = mem_r[rd_r];
    assign pulse = phase_r ? cur.data_pulse : cur.clk_pulse;

    // clock half first, then data half; idle cells give a quiet line
    always_comb begin
        wr_nxt = push ? ((wr_r == LAST) ? '0 : wr_r + PW'(1)) : wr_r;
        rd_nxt = pop ? ((rd_r == LAST) ? '0 : rd_r + PW'(1)) : rd_r;
        cnt_nxt = cnt_r + (PW + 1)'(push) - (PW + 1)'(pop);
        ready_nxt = (cnt_nxt != FULL);
        phase_nxt = phase_r;
        mfm_nxt = mfm_out;
        ahead_nxt = shift_ahead;
        behind_nxt = shift_behind;
        none_nxt = shift_none;
        if (dr_fall) begin
            phase_nxt = (cnt_r != '0) ? ~phase_r : 1'b0;
            mfm_nxt = (cnt_r != '0) && pulse;
            ahead_nxt = mfm_nxt && sync2_r.precomp_gate && cur.ahead;
            behind_nxt = mfm_nxt && sync2_r.precomp_gate && cur.behind;
            none_nxt = mfm_nxt && sync2_r.precomp_gate && !cur.ahead && !cur.behind;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (push) begin
            mem_r[wr_r] <= cell_in;
        end
        if (rst) begin
            wr_r <= '0;
            rd_r <= '0;
            cnt_r <= '0;
            phase_r <= 1'b0;
            enc_ready <= 1'b1;
            mfm_out <= 1'b0;
            shift_ahead <= 1'b0;
            shift_behind <= 1'b0;
            shift_none <= 1'b0;
        end else begin
            wr_r <= wr_nxt;
            rd_r <= rd_nxt;
            cnt_r <= cnt_nxt;
            phase_r <= phase_nxt;
            enc_ready <= ready_nxt;
            mfm_out <= mfm_nxt;
            shift_ahead <= ahead_nxt;
            shift_behind <= behind_nxt;
            shift_none <= none_nxt;
        end
    end

    // ----------------------------------------
    // request latches
    // ----------------------------------------
    logic tfr_nxt, svc_nxt, mc_n, sel_n, a_hi, a_lo;

    assign mc_n = sync2_r.master_clear_n;
    assign sel_n = sync2_r.select_n;
    assign a_hi = sync2_r.addr_bit_high;
    assign a_lo = sync2_r.addr_bit_low;

    // master clear beats everything; decode clear and strobe set never coincide
    always_comb begin
        tfr_nxt = transfer_request_n;
        svc_nxt = service_request_n;
        if (!mc_n) begin
            tfr_nxt = 1'b1;
            svc_nxt = 1'b1;
        end else if (!sel_n) begin
            if (a_hi && a_lo) begin
                svc_nxt = 1'b1;
            end else if (!a_hi && !a_lo) begin
                tfr_nxt = 1'b1;
            end
        end else begin
            if (tfr_fall) begin
                tfr_nxt = 1'b0;
            end
            if (svc_fall) begin
                svc_nxt = 1'b0;
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            transfer_request_n <= 1'b1;
            service_request_n <= 1'b1;
        end else begin
            transfer_request_n <= tfr_nxt;
            service_request_n <= svc_nxt;
        end
    end

    // ----------------------------------------
    // assertions
    // ----------------------------------------
    default clocking @(posedge ref_clk); endclocking
    default disable iff (rst);

    sequence s_first_one;
        skip_st_r == SK_ARMED && sync2_r.skip_arm && bit_fall && dbit;
    endsequence

    sequence s_delete_cell;
        skip_st_r == SK_COUNT && suppress && bit_fall;
    endsequence

    a_one_bit_taken: assert property (bit_fall && cnt_r != FULL && !pop |=> cnt_r == $past(cnt_r) + 1) else $error("bit not taken");
    a_clock_between_zeros: assert property (push && !suppress |-> cell_in.clk_pulse == (!dbit && !prev_d_r)) else $error("clock pulse wrong");
    a_precomp_gated: assert property (dr_fall && !sync2_r.precomp_gate |=> !shift_ahead && !shift_behind && !shift_none) else $error("precomp while gate low");
    a_precomp_onehot: assert property (dr_fall && mfm_nxt && sync2_r.precomp_gate |=> $onehot({shift_ahead, shift_behind, shift_none})) else $error("precomp not one hot");
    a_output_on_edge: assert property (!dr_fall |=> $stable(mfm_out) && $stable(shift_none)) else $error("output moved off edge");
    a_armed_zero: assert property (skip_st_r == SK_ARMED && sync2_r.skip_arm && bit_fall && !dbit |=> skip_st_r == SK_ARMED) else $error("zero changed skip");
    a_skip_start: assert property (s_first_one |=> skip_st_r == SK_COUNT && skip_cnt_r == 1) else $error("skip count not started");
    a_skip_delete: assert property (s_delete_cell |-> !cell_in.clk_pulse ##1 skip_st_r == SK_IDLE) else $error("skip did not delete and disarm");
    a_master_clear: assert property (!mc_n |=> transfer_request_n && service_request_n) else $error("master clear ignored");
    a_decode_clear: assert property (mc_n && !sel_n && a_hi && a_lo |=> service_request_n) else $error("service not cleared");
    a_strobe_set: assert property (mc_n && sel_n && tfr_fall |=> !transfer_request_n) else $error("transfer not set");
    a_request_holds: assert property (mc_n && (sel_n ? !svc_fall : a_hi != a_lo) |=> $stable(service_request_n)) else $error("service request moved");

endmodule

// *** testbench/mwe_far_model.sv ***
// write-channel side model: paces bit cells and collects the mfm halves
module mwe_far_model (
    // clock
    input wire logic ref_clk,
    // encoder outputs
    input wire logic mfm_out,
    input wire logic shift_ahead,
    input wire logic shift_behind,
    input wire logic shift_none,
    // pins toward the encoder
    output logic nrz_in,
    output logic bit_clk,
    output logic double_rate_clock
);
    timeunit 1ns;
    timeprecision 1ps;

    // ------------------------------------------------
    // idle levels
    // ------------------------------------------------
    initial begin
        nrz_in = 1'b0;
        bit_clk = 1'b1;
        double_rate_clock = 1'b1;
    end

    // one byte msb first, 16 cycles a cell; a short tail cell catches the
    // last data half, so the stream pauses between bytes
    task automatic send_byte(input logic [7:0] b, output logic [7:0] ck,
                             output logic [7:0] dt, output logic [23:0] sh);
        int n;
        sh = 24'h0;
        for (int i = 0; i <= 8; i++) begin
            n = (i == 8) ? 4 : 16;
            for (int k = 0; k < n; k++) begin
                @(negedge ref_clk);
                if (k == 0) begin
                    nrz_in = (i < 8) ? b[7 - i] : 1'b0;
                    bit_clk = 1'b1;
                    double_rate_clock = 1'b1;
                end
                if (k == 4)
                    bit_clk = 1'b0;
                if (k == 6 || k == 13)
                    double_rate_clock = 1'b0;
                if (k == 10)
                    double_rate_clock = 1'b1;
                // clock half of this cell
                if (k == 12) begin
                    ck[7 - i] = mfm_out;
                    sh[3 * (7 - i) +: 3] = {shift_ahead, shift_behind, shift_none};
                end
                // data half of the cell before
                if (k == 3 && i > 0) begin
                    dt[8 - i] = mfm_out;
                    sh[3 * (8 - i) +: 3] |= {shift_ahead, shift_behind, shift_none};
                end
            end
        end
    endtask

    // zero cells with no double rate fall, so the buffer fills up;
    // each level stands three cycles to clear the synchroniser
    task automatic push_only(input int n);
        for (int k = 0; k < 6 * n; k++) begin
            @(negedge ref_clk);
            nrz_in = 1'b0;
            bit_clk = ((k % 6) >= 3) ? 1'b0 : 1'b1;
        end
        @(negedge ref_clk);
        bit_clk = 1'b1;
    endtask

    // n double rate falls, one mfm half collected after each
    task automatic drain(input int n, output logic [7:0] got);
        got = 8'h0;
        for (int k = 1; k <= 6 * n; k++) begin
            @(negedge ref_clk);
            if (k % 6 == 0)
                got = {got[6:0], mfm_out};
            double_rate_clock = ((k % 6) < 3) ? 1'b1 : 1'b0;
        end
    endtask
endmodule

// *** testbench/testbench.sv ***
// self-checking bench for the mfm write encoder and request latches
module testbench;
    timeunit 1ns;
    timeprecision 1ps;

    // ------------------------------------------------
    // signals
    // ------------------------------------------------
    logic ref_clk, rst, skip_arm, precomp_gate;
    logic transfer_req_strobe, service_req_strobe, master_clear_n;
    logic select_n, addr_bit_low, addr_bit_high;
    logic nrz_in, bit_clk, double_rate_clock;
    logic mfm_out, shift_ahead, shift_behind, shift_none, enc_ready;
    logic transfer_request_n, service_request_n;
    logic pc, pd;
    int err_total, compares;

    mwe_top mwe_top_i (.ref_clk, .rst, .nrz_in, .bit_clk, .double_rate_clock,
        .skip_arm, .precomp_gate, .mfm_out, .shift_ahead, .shift_behind,
        .shift_none, .enc_ready, .transfer_req_strobe, .service_req_strobe,
        .master_clear_n, .select_n, .addr_bit_low, .addr_bit_high,
        .transfer_request_n, .service_request_n);

    mwe_far_model mwe_far_model_i (.ref_clk, .mfm_out, .shift_ahead,
        .shift_behind, .shift_none, .nrz_in, .bit_clk, .double_rate_clock);

    // ------------------------------------------------
    // helpers
    // ------------------------------------------------
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            err_total++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic stop_test;
        $display("compares=%0d err_total=%0d", compares, err_total);
        if (err_total == 0 && compares > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    // {ahead, behind, none} for window {prev clk, prev data, clk, data}
    function automatic logic [2:0] pcode(input logic [3:0] w);
        if (w[2:0] == 3'h6 || w == 4'h1)
            return 3'h4;
        if (w[2:0] == 3'h3 || w == 4'h8)
            return 3'h2;
        return 3'h1;
    endfunction

    // send one byte; del marks the cell whose clock the skip deletes
    task automatic enc(input logic [7:0] b, input logic del);
        logic [7:0] ck, dt, eck;
        logic [23:0] sh, esh;
        logic c;
        mwe_far_model_i.send_byte(b, ck, dt, sh);
        for (int i = 7; i >= 0; i--) begin
            c = !b[i] && !pd && !(del && i == 2);
            eck[i] = c;
            esh[3 * i +: 3] = (precomp_gate && (c || b[i])) ? pcode({pc, pd, c, b[i]}) : 3'h0;
            pc = c;
            pd = b[i];
        end
        chk(ck, eck);
        chk(dt, b);
        chk(sh, esh);
    endtask

    // ------------------------------------------------
    // scenarios
    // ------------------------------------------------
    task automatic t_reset;
        chk({mfm_out, enc_ready, transfer_request_n, service_request_n}, 4'h7);
    endtask

    task automatic t_encode;
        logic [7:0] bytes [4] = '{8'h00, 8'h5a, 8'hff, 8'h81};
        enc(8'h00, 1'b0);
        precomp_gate = 1'b1;
        foreach (bytes[j])
            enc(bytes[j], 1'b0);
    endtask

    task automatic t_skip;
        skip_arm = 1'b1;
        repeat (4) @(negedge ref_clk);
        enc(8'h00, 1'b0);
        enc(8'ha1, 1'b1);
        enc(8'ha1, 1'b0);
        skip_arm = 1'b0;
        enc(8'h00, 1'b0);
    endtask

    // three cells with no output clock: the third is refused, only two come out
    task automatic t_full;
        logic [7:0] got;
        mwe_far_model_i.push_only(3);
        chk(enc_ready, 1'b0);
        mwe_far_model_i.drain(6, got);
        chk({enc_ready, got}, 9'h128);
    endtask

    // entries {strobe_t, strobe_s, mclr_n, sel_n, a_hi, a_lo, exp_t, exp_s}
    task automatic t_req;
        logic [7:0] tbl [14] = '{8'hd3, 8'h30, 8'h34, 8'h28, 8'h2d, 8'h23,
            8'he3, 8'h27, 8'hb7, 8'h35, 8'h75, 8'h34, 8'h17, 8'h33};
        foreach (tbl[j]) begin
            @(negedge ref_clk);
            {transfer_req_strobe, service_req_strobe, master_clear_n, select_n,
             addr_bit_high, addr_bit_low} = tbl[j][7:2];
            repeat (4) @(negedge ref_clk);
            chk({transfer_request_n, service_request_n}, tbl[j][1:0]);
        end
    endtask

    // ------------------------------------------------
    // clock, main sequence and watchdog
    // ------------------------------------------------
    initial begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end

    initial begin
        rst = 1'b1;
        {skip_arm, precomp_gate, transfer_req_strobe, service_req_strobe} = 4'h0;
        {master_clear_n, select_n, addr_bit_low, addr_bit_high} = 4'hc;
        pc = 1'b0;
        pd = 1'b0;
        err_total = 0;
        compares = 0;
        repeat (2) @(negedge ref_clk);
        rst = 1'b0;
        t_reset;
        t_encode;
        t_skip;
        t_full;
        t_req;
        stop_test;
    end

    // roughly fifteen times the expected run
    initial begin
        repeat (20000) @(posedge ref_clk);
        err_total++;
        stop_test;
    end
endmodule
